// >>> rtl/pin_mux_regs.svh
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH
// Register byte offsets
`define OFS_PA_HIGH 12'h000
`define OFS_PB_LOW 12'h004
`define OFS_PB_HIGH 12'h008
`define OFS_PC_LOW 12'h00C
`define OFS_PC_HIGH 12'h010
`define OFS_PD_LOW 12'h014
`define OFS_SDI_SRC 12'h018
// Reset value of every select register
`define SEL_RESET 8'h00
// Writable bit masks of the port A high selector per variant, and of the SDI source selector
`define PA_MASK_SMALL 8'hCF
`define PA_MASK_MID 8'hFF
`define PA_MASK_LARGE 8'h0F
`define SDI_SRC_MASK 8'h03
// Field codes
`define CODE_GPIO 2'h0
`define CODE_ONE 2'h1
`define CODE_TWO 2'h2
`define CODE_THREE 2'h3
`endif

// >>> rtl/pin_mux_pkg.sv
package pin_mux_pkg;
  typedef enum logic [1:0] {
    VAR_SMALL = 2'h0,
    VAR_MID = 2'h1,
    VAR_LARGE = 2'h2
  } variant_e;

  typedef struct packed {
    logic [7:0] pa_high;
    logic [7:0] pb_low;
    logic [7:0] pb_high;
    logic [7:0] pc_low;
    logic [7:0] pc_high;
    logic [7:0] pd_low;
    logic [7:0] sdi_src;
  } regs_s;
endpackage : pin_mux_pkg

// >>> rtl/port_pin_function_mux.sv
`timescale 1ns/100ps
`include "pin_mux_regs.svh"
module port_pin_function_mux #(
  parameter pin_mux_pkg::variant_e VARIANT = pin_mux_pkg::VAR_MID
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // General I/O side, pins A4..A7, B0 and B4..B7, C0..C3
  input wire logic [3:0] gpio_a_out,
  input wire logic [3:0] gpio_a_oe_n,
  input wire logic [4:0] gpio_b_out,
  input wire logic [4:0] gpio_b_oe_n,
  input wire logic [3:0] gpio_c_out,
  input wire logic [3:0] gpio_c_oe_n,
  // Peripheral outputs
  input wire logic compact_timer1_out,
  input wire logic compact_timer0_out_inv,
  input wire logic periodic_timer_out_inv,
  input wire logic uart_tx,
  input wire logic spi_sdo,
  input wire logic sdi_out,
  input wire logic sdi_oe_n,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  // Pin drive, A4..A7, B0 and B4..B7, C0..C3
  output logic [3:0] pin_a_out,
  output logic [3:0] pin_a_oe_n,
  output logic [4:0] pin_b_out,
  output logic [4:0] pin_b_oe_n,
  output logic [3:0] pin_c_out,
  output logic [3:0] pin_c_oe_n,
  // Pin levels seen
  input wire logic [3:0] pin_a_in,
  input wire logic [4:0] pin_b_in,
  // Routed inputs and analog selects
  output logic uart_rx,
  output logic sck_in,
  output logic sdi_in,
  output logic ext_irq0_in,
  output logic ext_irq1_in,
  output logic compact_timer0_clk_in,
  output logic periodic_timer_clk_in,
  output logic standard_timer_clk_in,
  output logic periodic_timer_capture_in,
  output logic crystal_pin_two,
  output logic vref_sel,
  output logic [4:0] analog_sel,
  output logic [8:1] touch_key_sel
);

  pin_mux_pkg::regs_s r_q, r_d;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;

  // Writable mask of port A high selector per variant
  function automatic logic [7:0] pa_mask(input pin_mux_pkg::variant_e v);
    case (v)
      pin_mux_pkg::VAR_SMALL: pa_mask = `PA_MASK_SMALL;
      pin_mux_pkg::VAR_LARGE: pa_mask = `PA_MASK_LARGE;
      default: pa_mask = `PA_MASK_MID;
    endcase
  endfunction : pa_mask

  function automatic logic [1:0] fld(input logic [7:0] r, input int i);
    fld = r[2*i +: 2];
  endfunction : fld

  logic wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    r_d = r_q;
    rd_d = rdata_q;
    if (wr) begin
      case (paddr)
        `OFS_PA_HIGH: r_d.pa_high = pwdata[7:0] & pa_mask(VARIANT);
        `OFS_PB_LOW: r_d.pb_low = pwdata[7:0];
        `OFS_PB_HIGH: r_d.pb_high = pwdata[7:0];
        `OFS_PC_LOW: r_d.pc_low = pwdata[7:0];
        `OFS_PC_HIGH: r_d.pc_high = pwdata[7:0];
        `OFS_PD_LOW: r_d.pd_low = pwdata[7:0];
        `OFS_SDI_SRC: r_d.sdi_src = pwdata[7:0] & `SDI_SRC_MASK;
        default: ;
      endcase
    end
    if (rd) begin
      case (paddr)
        `OFS_PA_HIGH: rd_d = {24'h000000, r_q.pa_high};
        `OFS_PB_LOW: rd_d = {24'h000000, r_q.pb_low};
        `OFS_PB_HIGH: rd_d = {24'h000000, r_q.pb_high};
        `OFS_PC_LOW: rd_d = {24'h000000, r_q.pc_low};
        `OFS_PC_HIGH: rd_d = {24'h000000, r_q.pc_high};
        `OFS_PD_LOW: rd_d = {24'h000000, r_q.pd_low};
        `OFS_SDI_SRC: rd_d = {24'h000000, r_q.sdi_src};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= {7{`SEL_RESET}};
      rdata_q <= 32'h00000000;
    end else begin
      r_q <= r_d;
      rdata_q <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing
  logic [1:0] pin_a7_func_field, pin_a6_func_field, pin_a5_func_field, pin_a4_func_field;
  logic [1:0] pin_b0_func_field, pin_b7_func_field, pin_b6_func_field;
  logic [1:0] pin_b5_func_field, pin_b4_func_field;
  logic [1:0] serial_data_in_source_sel;
  assign pin_a4_func_field = fld(r_q.pa_high, 0);
  assign pin_a5_func_field = fld(r_q.pa_high, 1);
  assign pin_a6_func_field = fld(r_q.pa_high, 2);
  assign pin_a7_func_field = fld(r_q.pa_high, 3);
  assign pin_b0_func_field = fld(r_q.pb_low, 0);
  assign pin_b4_func_field = fld(r_q.pb_high, 0);
  assign pin_b5_func_field = fld(r_q.pb_high, 1);
  assign pin_b6_func_field = fld(r_q.pb_high, 2);
  assign pin_b7_func_field = fld(r_q.pb_high, 3);
  assign serial_data_in_source_sel = r_q.sdi_src[1:0];

  logic a5_tx, a5_sdi, a7_tx, a7_sdi, a6_rx, a6_sck;
  always_comb begin
    pin_a_out = gpio_a_out;
    pin_a_oe_n = gpio_a_oe_n;
    pin_b_out = gpio_b_out;
    pin_b_oe_n = gpio_b_oe_n;
    pin_c_out = gpio_c_out;
    pin_c_oe_n = gpio_c_oe_n;
    crystal_pin_two = 1'b0;
    vref_sel = 1'b0;
    analog_sel = 5'h00;
    touch_key_sel = 8'h00;
    a5_tx = 1'b0;
    a5_sdi = 1'b0;
    a7_tx = 1'b0;
    a7_sdi = 1'b0;
    a6_rx = 1'b0;
    a6_sck = 1'b0;
    // Pin A4
    case (pin_a4_func_field)
      `CODE_ONE: begin pin_a_out[0] = spi_sdo; pin_a_oe_n[0] = 1'b0; end
      `CODE_TWO: begin crystal_pin_two = 1'b1; pin_a_oe_n[0] = 1'b1; end
      default: ;
    endcase
    // Pin A5
    case (pin_a5_func_field)
      `CODE_ONE: begin pin_a_out[1] = compact_timer0_out_inv; pin_a_oe_n[1] = 1'b0; end
      `CODE_TWO: a5_tx = (VARIANT != pin_mux_pkg::VAR_LARGE);
      `CODE_THREE: a5_sdi = (VARIANT != pin_mux_pkg::VAR_LARGE);
      default: ;
    endcase
    if (a5_tx) begin pin_a_out[1] = uart_tx; pin_a_oe_n[1] = 1'b0; end
    if (a5_sdi) begin pin_a_out[1] = sdi_out; pin_a_oe_n[1] = sdi_oe_n; end
    // Pin A6 (middle variant only)
    if (VARIANT == pin_mux_pkg::VAR_MID) begin
      a6_rx = (pin_a6_func_field == `CODE_TWO);
      a6_sck = (pin_a6_func_field == `CODE_THREE);
    end
    if (a6_rx) pin_a_oe_n[2] = 1'b1;
    if (a6_sck) begin pin_a_out[2] = sck_out; pin_a_oe_n[2] = sck_oe_n; end
    // Pin A7
    if (VARIANT == pin_mux_pkg::VAR_SMALL && pin_a7_func_field == `CODE_ONE) begin
      pin_a_out[3] = compact_timer1_out;
      pin_a_oe_n[3] = 1'b0;
    end
    if (VARIANT == pin_mux_pkg::VAR_MID) begin
      a7_tx = (pin_a7_func_field == `CODE_TWO);
      a7_sdi = (pin_a7_func_field == `CODE_THREE);
    end
    if (a7_tx) begin pin_a_out[3] = uart_tx; pin_a_oe_n[3] = 1'b0; end
    if (a7_sdi) begin pin_a_out[3] = sdi_out; pin_a_oe_n[3] = sdi_oe_n; end
    // Pin B0
    case (pin_b0_func_field)
      `CODE_ONE: begin pin_b_out[0] = sdi_out; pin_b_oe_n[0] = sdi_oe_n; end
      `CODE_TWO: begin vref_sel = 1'b1; pin_b_oe_n[0] = 1'b1; end
      `CODE_THREE: begin analog_sel[0] = 1'b1; pin_b_oe_n[0] = 1'b1; end
      default: ;
    endcase
    // Pin B4
    case (pin_b4_func_field)
      `CODE_ONE: begin pin_b_out[1] = periodic_timer_out_inv; pin_b_oe_n[1] = 1'b0; end
      `CODE_TWO: begin touch_key_sel[1] = 1'b1; pin_b_oe_n[1] = 1'b1; end
      `CODE_THREE: begin analog_sel[1] = 1'b1; pin_b_oe_n[1] = 1'b1; end
      default: ;
    endcase
    // Pins B5..B7: key or analog, else GPIO with input function
    for (int i = 1; i < 4; i++) begin
      if (fld(r_q.pb_high, i) == `CODE_TWO) begin
        touch_key_sel[i+1] = 1'b1;
        pin_b_oe_n[i+1] = 1'b1;
      end else if (fld(r_q.pb_high, i) == `CODE_THREE) begin
        analog_sel[i+1] = 1'b1;
        pin_b_oe_n[i+1] = 1'b1;
      end
    end
    // Port C pins 0..3 to keys 5..8
    for (int i = 0; i < 4; i++) begin
      if (fld(r_q.pc_low, i) == `CODE_TWO) begin
        touch_key_sel[i+5] = 1'b1;
        pin_c_oe_n[i] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral inputs
  assign uart_rx = a6_rx ? pin_a_in[2] : 1'b1;
  assign sck_in = a6_sck ? pin_a_in[2] : 1'b1;
  assign ext_irq0_in = (!a6_rx && !a6_sck) ? pin_a_in[2] : 1'b0;
  assign compact_timer0_clk_in = ext_irq0_in;
  assign ext_irq1_in = (pin_b7_func_field[1] == 1'b0) ? pin_b_in[4] : 1'b0;
  assign periodic_timer_clk_in = (pin_b6_func_field[1] == 1'b0) ? pin_b_in[3] : 1'b0;
  assign standard_timer_clk_in = (pin_b5_func_field[1] == 1'b0) ? pin_b_in[2] : 1'b0;
  assign periodic_timer_capture_in =
    (pin_b4_func_field == `CODE_GPIO) ? pin_b_in[1] : 1'b0;
  // Source chosen only by its own selector
  assign sdi_in = serial_data_in_source_sel[0] ? pin_a_in[1] : pin_b_in[0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pa_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (r_q.pa_high & ~pa_mask(VARIANT)) == 8'h00)
    else $error("unimplemented port A bits set");
  a_b0_analog: assert property (@(posedge pclk) disable iff (!presetn)
    pin_b0_func_field == `CODE_THREE |-> analog_sel[0] && pin_b_oe_n[0])
    else $error("B0 analog route wrong");
  a_a4_sdo: assert property (@(posedge pclk) disable iff (!presetn)
    pin_a4_func_field == `CODE_ONE |-> pin_a_out[0] == spi_sdo && !pin_a_oe_n[0])
    else $error("A4 SDO route wrong");
  a_a5_inv: assert property (@(posedge pclk) disable iff (!presetn)
    pin_a5_func_field == `CODE_ONE |-> pin_a_out[1] == compact_timer0_out_inv)
    else $error("A5 timer route wrong");
  a_c_keys: assert property (@(posedge pclk) disable iff (!presetn)
    touch_key_sel[8:5] == {fld(r_q.pc_low, 3) == `CODE_TWO, fld(r_q.pc_low, 2) == `CODE_TWO,
      fld(r_q.pc_low, 1) == `CODE_TWO, fld(r_q.pc_low, 0) == `CODE_TWO})
    else $error("port C key route wrong");
  a_b4_inv: assert property (@(posedge pclk) disable iff (!presetn)
    pin_b4_func_field == `CODE_ONE |-> pin_b_out[1] == periodic_timer_out_inv)
    else $error("B4 timer route wrong");
  a_b7_key: assert property (@(posedge pclk) disable iff (!presetn)
    pin_b7_func_field == `CODE_TWO |-> touch_key_sel[4] && !ext_irq1_in)
    else $error("B7 key route wrong");
  a_gpio_dup: assert property (@(posedge pclk) disable iff (!presetn)
    pin_b6_func_field == `CODE_ONE |-> pin_b_out[3] == gpio_b_out[3]
      && !touch_key_sel[3] && !analog_sel[3])
    else $error("B6 duplicate code not GPIO");
  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `OFS_PB_HIGH |=> r_q.pb_high == $past(pwdata[7:0]))
    else $error("write did not land");

endmodule : port_pin_function_mux

// >>> test/pin_side_model.sv
`timescale 1ns/100ps
module pin_side_model #(
  parameter int SEED0 = 32'h0000_1D2B
) (
  // Clock
  input wire logic pclk,
  // Pin drive from the mux
  input wire logic [3:0] pin_a_out,
  input wire logic [3:0] pin_a_oe_n,
  input wire logic [4:0] pin_b_out,
  input wire logic [4:0] pin_b_oe_n,
  // Pin levels and peripheral drives
  output logic [3:0] pin_a_in,
  output logic [4:0] pin_b_in,
  output logic [8:0] periph
);
  logic [3:0] last_a = 4'h0;
  logic [4:0] last_b = 5'h00;
  integer seed = SEED0;
  // Released pins show the inverse of their last level
  assign pin_a_in = (~pin_a_oe_n & pin_a_out) | (pin_a_oe_n & ~last_a);
  assign pin_b_in = (~pin_b_oe_n & pin_b_out) | (pin_b_oe_n & ~last_b);
  initial begin
    periph = 9'h000;
  end
  always @(posedge pclk) begin
    last_a <= pin_a_in;
    last_b <= pin_b_in;
    periph <= 9'($random(seed));
  end
endmodule : pin_side_model

// >>> test/port_pin_function_mux_test.sv
`timescale 1ns/100ps
`include "pin_mux_regs.svh"
module port_pin_function_mux_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] gpio_a_out, gpio_a_oe_n, gpio_c_out, gpio_c_oe_n;
  logic [3:0] pin_a_out, pin_a_oe_n, pin_c_out, pin_c_oe_n, pin_a_in;
  logic [4:0] gpio_b_out, gpio_b_oe_n, pin_b_out, pin_b_oe_n, pin_b_in, analog_sel, aexp;
  logic [8:0] pv;
  logic [8:1] touch_key_sel, kexp;
  logic uart_rx, sck_in, sdi_in, irq0, irq1, ct0clk, ptclk, stclk, ptcap, xtal, vref_sel;
  logic [7:0] r [7];
  int n_errors = 0;
  int samples_checked = 0;
  integer seed = 32'h9BEB;
  port_pin_function_mux DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_a_out(gpio_a_out), .gpio_a_oe_n(gpio_a_oe_n),
    .gpio_b_out(gpio_b_out), .gpio_b_oe_n(gpio_b_oe_n), .gpio_c_out(gpio_c_out),
    .gpio_c_oe_n(gpio_c_oe_n), .compact_timer1_out(pv[0]), .compact_timer0_out_inv(pv[1]),
    .periodic_timer_out_inv(pv[2]), .uart_tx(pv[3]), .spi_sdo(pv[4]), .sdi_out(pv[5]),
    .sdi_oe_n(pv[6]), .sck_out(pv[7]), .sck_oe_n(pv[8]), .pin_a_out(pin_a_out),
    .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n),
    .pin_c_out(pin_c_out), .pin_c_oe_n(pin_c_oe_n), .pin_a_in(pin_a_in), .pin_b_in(pin_b_in),
    .uart_rx(uart_rx), .sck_in(sck_in), .sdi_in(sdi_in), .ext_irq0_in(irq0),
    .ext_irq1_in(irq1), .compact_timer0_clk_in(ct0clk), .periodic_timer_clk_in(ptclk),
    .standard_timer_clk_in(stclk), .periodic_timer_capture_in(ptcap),
    .crystal_pin_two(xtal), .vref_sel(vref_sel), .analog_sel(analog_sel),
    .touch_key_sel(touch_key_sel));
  pin_side_model far_side (.pclk(pclk), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
    .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n), .pin_a_in(pin_a_in),
    .pin_b_in(pin_b_in), .periph(pv));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task chk_out(input logic [1:0] c, input logic [3:0] m, input logic s, input logic [3:0] v,
    input string what);
    if (m[c]) begin
      check({31'h0, s}, {31'h0, v[c]}, what);
    end
  endtask : chk_out
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: bus answer timed out", $time);
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task give_verdict;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #2000000;
    n_errors++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {gpio_a_out, gpio_a_oe_n, gpio_b_out, gpio_b_oe_n, gpio_c_out, gpio_c_oe_n} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check(q, 32'h0, "reset value");
      check({pready, pslverr}, 2'b10, "bus response");
    end
    for (int k = 0; k < 60; k++) begin
      for (int i = 0; i < 7; i++) begin
        r[i] = (k == 0) ? 8'hAA : (k == 1) ? 8'hFF : (k == 2) ? 8'h55 : 8'($random(seed));
        apb(1'b1, 12'(4 * i), {24'($random(seed)), r[i]});
      end
      apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
      for (int i = 0; i < 8; i++) begin
        apb(1'b0, 12'(4 * i), 32'h0);
        check(q, (i == 7) ? 32'h0 : {24'h0, (i == 6) ? r[6] & `SDI_SRC_MASK : r[i]}, "rd");
      end
      @(posedge pclk);
      {gpio_a_out, gpio_a_oe_n, gpio_b_out, gpio_b_oe_n} <= 18'($random(seed));
      {gpio_c_out, gpio_c_oe_n} <= 8'($random(seed));
      @(negedge pclk);
      chk_out(r[0][1:0], 4'hB, pin_a_out[0], {gpio_a_out[0], 1'b0, pv[4], gpio_a_out[0]}, "a4");
      chk_out(r[0][1:0], 4'hF, pin_a_oe_n[0], {gpio_a_oe_n[0], 2'b10, gpio_a_oe_n[0]},
        "a4 oe");
      chk_out(r[1][1:0], 4'hF, pin_b_oe_n[0], {2'b11, pv[6], gpio_b_oe_n[0]}, "b0 oe");
      chk_out(r[0][3:2], 4'hF, pin_a_out[1], {pv[5], pv[3], pv[1], gpio_a_out[1]}, "a5");
      chk_out(r[0][3:2], 4'hF, pin_a_oe_n[1], {pv[6], 2'b00, gpio_a_oe_n[1]}, "a5 oe");
      chk_out(r[0][5:4], 4'hB, pin_a_out[2], {pv[7], 1'b0, {2{gpio_a_out[2]}}}, "a6");
      chk_out(r[0][7:6], 4'hF, pin_a_out[3], {pv[5], pv[3], {2{gpio_a_out[3]}}}, "a7");
      chk_out(r[1][1:0], 4'h3, pin_b_out[0], {2'b00, pv[5], gpio_b_out[0]}, "b0");
      chk_out(r[2][1:0], 4'h3, pin_b_out[1], {2'b00, pv[2], gpio_b_out[1]}, "b4");
      aexp = {4'h0, r[1][1:0] == 2'h3};
      for (int j = 0; j < 4; j++) begin
        if (j > 0) chk_out(r[2][2*j+:2], 4'h3, pin_b_out[j+1], {2'b00, {2{gpio_b_out[j+1]}}}, "b");
        chk_out(r[3][2*j+:2], 4'hB, pin_c_out[j], {gpio_c_out[j], 1'b0, {2{gpio_c_out[j]}}}, "c");
        chk_out(r[3][2*j+:2], 4'hB, pin_c_oe_n[j], {gpio_c_oe_n[j], 1'b0, {2{gpio_c_oe_n[j]}}}, "coe");
        kexp[j+1] = r[2][2*j+:2] == 2'h2;
        kexp[j+5] = r[3][2*j+:2] == 2'h2;
        aexp[j+1] = r[2][2*j+:2] == 2'h3;
      end
      check(touch_key_sel, kexp, "keys");
      check(analog_sel, aexp, "analog");
      check(vref_sel, r[1][1:0] == 2'h2, "vref");
      check(xtal, r[0][1:0] == 2'h2, "xtal");
      check(irq1, r[2][7:6] < 2'h2 && pin_b_in[4], "irq1");
      check(ptclk, r[2][5:4] < 2'h2 && pin_b_in[3], "ptclk");
      check(stclk, r[2][3:2] < 2'h2 && pin_b_in[2], "stclk");
      check(ptcap, r[2][1:0] == 2'h0 && pin_b_in[1], "cap");
      check(irq0, r[0][5:4] < 2'h2 && pin_a_in[2], "irq0");
      check(ct0clk, r[0][5:4] < 2'h2 && pin_a_in[2], "ct0 clk");
      check(sck_in, (r[0][5:4] == 2'h3) ? pin_a_in[2] : 1'b1, "sck in");
      if (r[0][5:4] == 2'h2) check(uart_rx, pin_a_in[2], "rx");
      check(sdi_in, r[6][0] ? pin_a_in[1] : pin_b_in[0], "sdi in");
    end
    give_verdict;
  end
endmodule : port_pin_function_mux_test
